// file: tb/ddrini_ctrl_sva.sv
`timescale 1ns/1ps
module ddrini_ctrl_sva (
  // Clock, reset and user side
  input wire logic CLOCK_I,
  input wire logic RST_N_I,
  input wire logic CE_I,
  input wire logic START_I,
  input wire logic BUSY_O,
  input wire logic INIT_DONE_O,
  // Memory command bus
  input wire logic DDR_CKE_O,
  input wire logic DDR_ODT_O,
  input wire logic DDR_CS_N_O,
  input wire logic DDR_RAS_N_O,
  input wire logic DDR_CAS_N_O,
  input wire logic DDR_WE_N_O,
  input wire logic [2:0] DDR_BA_O,
  input wire logic [15:0] DDR_ADDR_O
);
  default clocking cb @(posedge CLOCK_I);
  endclocking
  default disable iff (!RST_N_I);
  logic [3:0] pins;
  logic idle;
  logic is_lm;
  logic is_pre;
  logic is_dll;
  logic [8:0] cke_cnt_q;
  logic [8:0] cke_cnt_d;
  logic [8:0] dll_cnt_q;
  logic [8:0] dll_cnt_d;
  assign pins = {DDR_CS_N_O, DDR_RAS_N_O, DDR_CAS_N_O, DDR_WE_N_O};
  assign idle = pins == ddrini_pkg::PINS_NOP || pins == ddrini_pkg::PINS_DESEL;
  assign is_lm = pins == ddrini_pkg::PINS_LM;
  assign is_pre = pins == ddrini_pkg::PINS_PRE;
  assign is_dll = is_lm && DDR_BA_O == 3'h0 && DDR_ADDR_O[8];
  // Counters saturate so that a long run cannot wrap them back past a bound.
  always_comb
  begin
    cke_cnt_d = cke_cnt_q;
    dll_cnt_d = dll_cnt_q;
    if (!DDR_CKE_O)
      cke_cnt_d = 9'h000;
    else if (cke_cnt_q != 9'h1ff)
      cke_cnt_d = cke_cnt_q + 9'h001;
    if (is_dll)
      dll_cnt_d = 9'h001;
    else if (dll_cnt_q != 9'h000 && dll_cnt_q != 9'h1ff)
      dll_cnt_d = dll_cnt_q + 9'h001;
  end
  always_ff @(posedge CLOCK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      cke_cnt_q <= 9'h000;
      dll_cnt_q <= 9'h000;
    end
    else
    begin
      cke_cnt_q <= cke_cnt_d;
      dll_cnt_q <= dll_cnt_d;
    end
  end
  property p_odt_off;
    DDR_ODT_O == 1'b0;
  endproperty
  a_odt_off: assert property (p_odt_off)
    else $error("termination input driven high");
  property p_cke_held;
    DDR_CKE_O |=> DDR_CKE_O;
  endproperty
  a_cke_held: assert property (p_cke_held)
    else $error("clock enable dropped after rising");
  property p_nop_before_cke;
    !DDR_CKE_O |-> idle;
  endproperty
  a_nop_before_cke: assert property (p_nop_before_cke)
    else $error("command issued while clock enable low");
  property p_cke_wait;
    is_pre |-> DDR_ADDR_O[10] && cke_cnt_q >= ddrini_pkg::CKE_WAIT_CYC;
  endproperty
  a_cke_wait: assert property (p_cke_wait)
    else $error("precharge too early or not to all banks");
  property p_upper_row;
    DDR_ADDR_O[15:13] == 3'h0;
  endproperty
  a_upper_row: assert property (p_upper_row)
    else $error("reserved row address bits driven");
  property p_cmd_single;
    (!idle && CE_I) |=> idle;
  endproperty
  a_cmd_single: assert property (p_cmd_single)
    else $error("command held longer than one cycle");
  property p_lm_gap;
    (is_lm && CE_I) |=> idle [*2];
  endproperty
  a_lm_gap: assert property (p_lm_gap)
    else $error("command inside mode set delay");
  property p_dll_cke;
    is_dll |-> DDR_CKE_O ##1 DDR_CKE_O [*8];
  endproperty
  a_dll_cke: assert property (p_dll_cke)
    else $error("clock enable low during lock time");
  property p_dll_lock;
    $rose(INIT_DONE_O) |-> dll_cnt_q >= ddrini_pkg::DLL_LOCK_CYC;
  endproperty
  a_dll_lock: assert property (p_dll_lock)
    else $error("done before lock time elapsed");
  property p_done_holds;
    INIT_DONE_O |=> INIT_DONE_O && !BUSY_O;
  endproperty
  a_done_holds: assert property (p_done_holds)
    else $error("done dropped or busy again");
  // The edge that releases reset still sees reset in the design, so a start
  // held across the release is only taken one edge later.
  property p_start_busy;
    (RST_N_I && START_I && CE_I && !BUSY_O && !INIT_DONE_O) |=> BUSY_O;
  endproperty
  a_start_busy: assert property (p_start_busy)
    else $error("start not taken");
  c_dll: cover property (is_dll);
  c_done: cover property ($rose(INIT_DONE_O));
  c_freeze: cover property (BUSY_O && !CE_I);
endmodule : ddrini_ctrl_sva

bind ddrini_ctrl ddrini_ctrl_sva ddrini_ctrl_sva_i (
  .CLOCK_I(CLOCK_I), .RST_N_I(RST_N_I), .CE_I(CE_I), .START_I(START_I),
  .BUSY_O(BUSY_O), .INIT_DONE_O(INIT_DONE_O), .DDR_CKE_O(DDR_CKE_O),
  .DDR_ODT_O(DDR_ODT_O), .DDR_CS_N_O(DDR_CS_N_O), .DDR_RAS_N_O(DDR_RAS_N_O),
  .DDR_CAS_N_O(DDR_CAS_N_O), .DDR_WE_N_O(DDR_WE_N_O), .DDR_BA_O(DDR_BA_O),
  .DDR_ADDR_O(DDR_ADDR_O));

// file: tb/ddrini_ctrl_tb.sv
`timescale 1ns/1ps
module ddrini_ctrl_tb;
  localparam int STABLE = 20;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic ce = 1'b1;
  logic start = 1'b0;
  logic [12:0] mr = 13'h0000;
  logic [12:0] emr = 13'h0000;
  logic ht = 1'b0;
  logic busy, done, cke, cs_n, ras_n, cas_n, we_n, odt;
  logic [2:0] ba;
  logic [15:0] addr;
  int mismatches = 0;
  int n_tests = 0;
  always #10 clk = ~clk;
  ddrini_ctrl #(.STABLE_CYC(STABLE)) ddrini_ctrl_i (.CLOCK_I(clk),
    .RST_N_I(rst_n), .CE_I(ce), .START_I(start), .MR_SETTINGS_I(mr),
    .EMR_SETTINGS_I(emr), .EMR2_HIGH_TEMP_I(ht), .BUSY_O(busy),
    .INIT_DONE_O(done), .DDR_CKE_O(cke), .DDR_ODT_O(odt), .DDR_CS_N_O(cs_n),
    .DDR_RAS_N_O(ras_n), .DDR_CAS_N_O(cas_n), .DDR_WE_N_O(we_n),
    .DDR_BA_O(ba), .DDR_ADDR_O(addr));
  ddrini_mem_model mm (.clk_i(clk), .rst_n_i(rst_n), .cke_i(cke),
    .cs_n_i(cs_n), .ras_n_i(ras_n), .cas_n_i(cas_n), .we_n_i(we_n),
    .ba_i(ba), .addr_i(addr));
  task automatic check(input string nm, input logic [15:0] e,
                       input logic [15:0] g);
    n_tests++;
    if (g !== e)
    begin
      $display("ERROR %s expected %h seen %h", nm, e, g);
      mismatches++;
    end
  endtask : check
  task automatic complete_run;
    $display("Checks %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : complete_run
  task automatic run_init(input logic [12:0] ms, input logic [12:0] es,
                          input logic h);
    int st;
    int k;
    logic [15:0] m;
    logic [15:0] e;
    logic [15:0] ea [11];
    logic [3:0] ec [11];
    logic [2:0] eb [11];
    @(posedge clk);
    mr <= ms;
    emr <= es;
    ht <= h;
    start <= 1'b1;
    @(posedge clk);
    #1 st = mm.cyc;
    @(posedge clk);
    start <= 1'b0;
    for (k = 0; k < 3000 && done !== 1'b1; k++)
      @(posedge clk);
    #1;
    check("init_done", 16'h1, {15'h0, done});
    if (done !== 1'b1)
      complete_run();
    m = {3'h0, ms & 13'h1e7f};
    e = {3'h0, es & 13'h1c7e};
    ea = '{16'h0400, {8'h0, h, 7'h0}, 16'h0, e, m | 16'h0100, 16'h0400,
           16'h0, 16'h0, m, e | 16'h0380, e};
    // Pin codes in cs_n, ras_n, cas_n, we_n order.
    ec = '{4'h2, 4'h0, 4'h0, 4'h0, 4'h0, 4'h2, 4'h1, 4'h1, 4'h0, 4'h0, 4'h0};
    eb = '{3'h0, 3'h2, 3'h3, 3'h1, 3'h0, 3'h0, 3'h0, 3'h0, 3'h0, 3'h1, 3'h1};
    check("cmd_count", 16'h000b, 16'(mm.n));
    for (k = 0; k < 11; k++)
    begin
      check("cmd", ec[k], mm.log_cmd[k]);
      if (ec[k] == 4'h0)
        check("lm_ba", eb[k], mm.log_ba[k]);
      if (ec[k] == 4'h0)
        check("lm_addr", ea[k], mm.log_addr[k]);
      if (ec[k] == 4'h2)
        check("pre_all", 16'h1, mm.log_addr[k][10]);
      if (k > 0)
        check("gap", 16'h1, mm.log_cyc[k] - mm.log_cyc[k-1] >= 2);
    end
    check("settle", 16'h1, mm.cke_cyc - st >= STABLE);
    check("cke_wait", 16'h1, mm.log_cyc[0] - mm.cke_cyc >= 20);
    // Refresh cycle time of 128 ns rounds up to 7 clocks.
    check("ref_gap", 16'h1, mm.log_cyc[7] - mm.log_cyc[6] >= 7);
    check("dll_lock", 16'h1, mm.cyc - mm.dll_cyc >= 200);
    check("mr_final", m, {3'h0, mm.mode_q[0]});
    check("emr_final", e, {3'h0, mm.mode_q[1]});
    check("strobe", {15'h0, ~es[10]}, {15'h0, mm.strobe_pair});
  endtask : run_init
  initial
  begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    run_init(13'h1fff, 13'h1fff, 1'b1);
    @(posedge clk);
    start <= 1'b1;
    repeat (5) @(posedge clk);
    #1 check("no_restart", 16'h1, {14'h0, busy, done});
    @(posedge clk);
    rst_n <= 1'b0;
    @(posedge clk);
    rst_n <= 1'b1;
    repeat (10) @(posedge clk);
    ce <= 1'b0;
    repeat (8) @(posedge clk);
    #1 check("freeze", 16'h2, {14'h0, busy, cke});
    check("odt_off", 16'h0, {15'h0, odt});
    @(posedge clk);
    ce <= 1'b1;
    rst_n <= 1'b0;
    @(posedge clk);
    #1;
    check("rst_pins", 16'h0f, {11'h0, cke, cs_n, ras_n, cas_n, we_n});
    @(posedge clk);
    rst_n <= 1'b1;
    start <= 1'b0;
    run_init(13'h0a52, 13'h0044, 1'b0);
    complete_run();
  end
endmodule : ddrini_ctrl_tb

// file: tb/ddrini_mem_model.sv
`timescale 1ns/1ps
module ddrini_mem_model (
  // Clock and log reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Command pins
  input wire logic cke_i,
  input wire logic cs_n_i,
  input wire logic ras_n_i,
  input wire logic cas_n_i,
  input wire logic we_n_i,
  input wire logic [2:0] ba_i,
  input wire logic [15:0] addr_i
);
  int cyc = 0;
  int n = 0;
  int cke_cyc = 0;
  int dll_cyc = 0;
  logic [3:0] log_cmd [16];
  logic [2:0] log_ba [16];
  logic [15:0] log_addr [16];
  int log_cyc [16];
  // One register per bank code, so all eight codes decode apart.
  logic [12:0] mode_q [8];
  // Bring-up moves no data; an access would leave the core as four
  // half-clock beats at the pins, two per clock.
  localparam int BEATS_PER_ACCESS = 4;
  logic [3:0] pins;
  logic strobe_pair;
  assign pins = {cs_n_i, ras_n_i, cas_n_i, we_n_i};
  // Complement strobes serve only while the disable bit is clear.
  assign strobe_pair = ~mode_q[1][10];
  always @(posedge clk_i)
  begin
    cyc = cyc + 1;
    if (!rst_n_i)
    begin
      n = 0;
      cke_cyc = 0;
    end
    else
    begin
      if (cke_i && cke_cyc == 0)
        cke_cyc = cyc;
      if (cke_i && !cs_n_i && pins != ddrini_pkg::PINS_NOP && n < 16)
      begin
        log_cmd[n] = pins;
        log_ba[n] = ba_i;
        log_addr[n] = addr_i;
        log_cyc[n] = cyc;
        n = n + 1;
        if (pins == ddrini_pkg::PINS_LM)
          mode_q[ba_i] = addr_i[12:0];
        if (pins == ddrini_pkg::PINS_LM && ba_i == 3'h0 && addr_i[8])
        begin
          dll_cyc = cyc;
          mode_q[0][8] = 1'b0;
        end
      end
    end
  end
endmodule : ddrini_mem_model

// file: verilog/ddrini_cmd_drv.sv
`timescale 1ns/1ps
module ddrini_cmd_drv (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  // Command request
  input wire ddrini_pkg::ddrini_cmd_t cmd_i,
  input wire logic [2:0] ba_i,
  input wire logic [15:0] addr_i,
  input wire logic cke_i,
  // Memory pins
  output logic cs_n_o,
  output logic ras_n_o,
  output logic cas_n_o,
  output logic we_n_o,
  output logic [2:0] ba_o,
  output logic [15:0] addr_o,
  output logic cke_o,
  output logic odt_o
);

  logic [3:0] pins_d;
  logic [3:0] pins_q;
  logic [2:0] ba_q;
  logic [15:0] addr_q;
  logic cke_q;

  always_comb
  begin
    unique case (cmd_i)
      ddrini_pkg::CMD_NOP: pins_d = ddrini_pkg::PINS_NOP;
      ddrini_pkg::CMD_PRE: pins_d = ddrini_pkg::PINS_PRE;
      ddrini_pkg::CMD_LM: pins_d = ddrini_pkg::PINS_LM;
      ddrini_pkg::CMD_REF: pins_d = ddrini_pkg::PINS_REF;
      ddrini_pkg::CMD_DESEL: pins_d = ddrini_pkg::PINS_DESEL;
      default: pins_d = ddrini_pkg::PINS_NOP;
    endcase
  end

  // Reset leaves the bus deselected with CKE low.
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      pins_q <= ddrini_pkg::PINS_DESEL;
      ba_q <= 3'h0;
      addr_q <= 16'h0000;
      cke_q <= 1'b0;
    end
    else if (ce_i)
    begin
      pins_q <= pins_d;
      ba_q <= ba_i;
      addr_q <= addr_i;
      cke_q <= cke_i;
    end
  end

  assign cs_n_o = pins_q[3];
  assign ras_n_o = pins_q[2];
  assign cas_n_o = pins_q[1];
  assign we_n_o = pins_q[0];
  assign ba_o = ba_q;
  assign addr_o = addr_q;
  assign cke_o = cke_q;
  // Termination stays off for the whole bring-up.
  assign odt_o = 1'b0;

endmodule : ddrini_cmd_drv

// file: verilog/ddrini_ctrl.sv
`timescale 1ns/1ps
module ddrini_ctrl #(
  parameter int STABLE_CYC = ddrini_pkg::STABLE_CYC,
  parameter int TMRD_CYC = ddrini_pkg::TMRD_CYC_DEF,
  parameter int TRP_NS = ddrini_pkg::TRP_NS_DEF,
  parameter int TRFC_NS = ddrini_pkg::TRFC_NS_DEF,
  parameter int NUM_REFRESH = ddrini_pkg::NUM_REFRESH_DEF
) (
  // Clock, reset and clock enable
  input wire logic CLOCK_I,
  input wire logic RST_N_I,
  input wire logic CE_I,
  // User side
  input wire logic START_I,
  input wire logic [12:0] MR_SETTINGS_I,
  input wire logic [12:0] EMR_SETTINGS_I,
  input wire logic EMR2_HIGH_TEMP_I,
  output logic BUSY_O,
  output logic INIT_DONE_O,
  // Memory command bus
  output logic DDR_CKE_O,
  output logic DDR_ODT_O,
  output logic DDR_CS_N_O,
  output logic DDR_RAS_N_O,
  output logic DDR_CAS_N_O,
  output logic DDR_WE_N_O,
  output logic [2:0] DDR_BA_O,
  output logic [15:0] DDR_ADDR_O
);

  localparam int TW = ddrini_pkg::TIMER_W;
  localparam int P = ddrini_pkg::CLK_PERIOD_NS;
  localparam int TRP_RAW = (TRP_NS + P - 1) / P;
  localparam int TRFC_RAW = (TRFC_NS + P - 1) / P;
  localparam int TRP_CYC = (TRP_RAW < 1) ? 1 : TRP_RAW;
  localparam int TRFC_CYC = (TRFC_RAW < 1) ? 1 : TRFC_RAW;
  localparam int MRD_CYC = (TMRD_CYC < 1) ? 1 : TMRD_CYC;

  typedef enum logic [3:0] {
    ST_IDLE,
    ST_STABLE,
    ST_CKE_WAIT,
    ST_PRE_ALL1,
    ST_EMR2,
    ST_EMR3,
    ST_EMR_DLL,
    ST_MR_DLLRST,
    ST_PRE_ALL2,
    ST_REFRESH,
    ST_MR_OP,
    ST_EMR_OCD_DEF,
    ST_EMR_OCD_EXIT,
    ST_DLL_WAIT,
    ST_DONE
  } ddrini_state_t;

  ddrini_state_t state_q;
  ddrini_state_t state_d;
  logic [3:0] ref_cnt_q;
  logic [3:0] ref_cnt_d;
  logic [12:0] mr_q;
  logic [12:0] mr_d;
  logic [12:0] emr_q;
  logic [12:0] emr_d;
  logic htsr_q;
  logic htsr_d;
  logic cke_q;
  logic cke_d;

  ddrini_pkg::ddrini_cmd_t cmd;
  logic [2:0] ba;
  logic [15:0] addr;
  logic [15:0] mr_base;
  logic [15:0] emr_base;
  logic t_load;
  logic [TW-1:0] t_value;
  logic t_done;
  logic dll_load;
  logic dll_done;

  // Operating-mode images with the fields this sequence owns cleared.
  // Upper row bits stay zero on every load.
  always_comb
  begin
    mr_base = 16'h0000;
    mr_base[12:0] = mr_q;
    mr_base[ddrini_pkg::TEST_MODE_BIT] = 1'b0;
    mr_base[ddrini_pkg::DLL_RESET_BIT] = 1'b0;
    emr_base = 16'h0000;
    // Strobe-disable bit passes through from the user settings.
    emr_base[12:0] = emr_q;
    emr_base[ddrini_pkg::DLL_DISABLE_BIT] = 1'b0;
    emr_base[ddrini_pkg::DRIVE_CAL_BIT_LOW] = 1'b0;
    emr_base[ddrini_pkg::DRIVE_CAL_BIT_MID] = 1'b0;
    emr_base[ddrini_pkg::DRIVE_CAL_BIT_HIGH] = 1'b0;
  end

  always_comb
  begin
    state_d = state_q;
    ref_cnt_d = ref_cnt_q;
    mr_d = mr_q;
    emr_d = emr_q;
    htsr_d = htsr_q;
    cke_d = cke_q;
    cmd = ddrini_pkg::CMD_NOP;
    ba = 3'h0;
    addr = 16'h0000;
    t_load = 1'b0;
    t_value = '0;
    dll_load = 1'b0;
    unique case (state_q)
      ST_IDLE:
      begin
        // Bus stays on NOP with CKE low until told to start.
        if (START_I)
        begin
          mr_d = MR_SETTINGS_I;
          emr_d = EMR_SETTINGS_I;
          htsr_d = EMR2_HIGH_TEMP_I;
          t_load = 1'b1;
          t_value = TW'(STABLE_CYC);
          state_d = ST_STABLE;
        end
      end
      ST_STABLE:
      begin
        if (t_done)
        begin
          cke_d = 1'b1;
          t_load = 1'b1;
          t_value = TW'(ddrini_pkg::CKE_WAIT_CYC);
          state_d = ST_CKE_WAIT;
        end
      end
      ST_CKE_WAIT:
      begin
        if (t_done)
        begin
          state_d = ST_PRE_ALL1;
        end
      end
      ST_PRE_ALL1:
      begin
        cmd = ddrini_pkg::CMD_PRE;
        addr[ddrini_pkg::PRECHARGE_ALL_BIT] = 1'b1;
        t_load = 1'b1;
        t_value = TW'(TRP_CYC);
        state_d = ST_EMR2;
      end
      ST_EMR2:
      begin
        if (t_done)
        begin
          cmd = ddrini_pkg::CMD_LM;
          ba = ddrini_pkg::BA_EMR2;
          addr[ddrini_pkg::HIGH_TEMP_SR_BIT] = htsr_q;
          t_load = 1'b1;
          t_value = TW'(MRD_CYC);
          state_d = ST_EMR3;
        end
      end
      ST_EMR3:
      begin
        if (t_done)
        begin
          cmd = ddrini_pkg::CMD_LM;
          ba = ddrini_pkg::BA_EMR3;
          t_load = 1'b1;
          t_value = TW'(MRD_CYC);
          state_d = ST_EMR_DLL;
        end
      end
      ST_EMR_DLL:
      begin
        if (t_done)
        begin
          cmd = ddrini_pkg::CMD_LM;
          ba = ddrini_pkg::BA_EMR;
          addr = emr_base;
          t_load = 1'b1;
          t_value = TW'(MRD_CYC);
          state_d = ST_MR_DLLRST;
        end
      end
      ST_MR_DLLRST:
      begin
        if (t_done)
        begin
          cmd = ddrini_pkg::CMD_LM;
          ba = ddrini_pkg::BA_MR;
          addr = mr_base;
          addr[ddrini_pkg::DLL_RESET_BIT] = 1'b1;
          // Lock time is counted from this load, in parallel with the rest.
          dll_load = 1'b1;
          t_load = 1'b1;
          t_value = TW'(MRD_CYC);
          state_d = ST_PRE_ALL2;
        end
      end
      ST_PRE_ALL2:
      begin
        if (t_done)
        begin
          cmd = ddrini_pkg::CMD_PRE;
          addr[ddrini_pkg::PRECHARGE_ALL_BIT] = 1'b1;
          ref_cnt_d = 4'h0;
          t_load = 1'b1;
          t_value = TW'(TRP_CYC);
          state_d = ST_REFRESH;
        end
      end
      ST_REFRESH:
      begin
        if (t_done)
        begin
          cmd = ddrini_pkg::CMD_REF;
          ref_cnt_d = ref_cnt_q + 4'h1;
          t_load = 1'b1;
          t_value = TW'(TRFC_CYC);
          if (ref_cnt_q >= 4'(NUM_REFRESH - 1))
          begin
            state_d = ST_MR_OP;
          end
        end
      end
      ST_MR_OP:
      begin
        if (t_done)
        begin
          // Writing the reset bit low here keeps us independent of
          // the device clearing it by itself.
          cmd = ddrini_pkg::CMD_LM;
          ba = ddrini_pkg::BA_MR;
          addr = mr_base;
          t_load = 1'b1;
          t_value = TW'(MRD_CYC);
          state_d = ST_EMR_OCD_DEF;
        end
      end
      ST_EMR_OCD_DEF:
      begin
        if (t_done)
        begin
          cmd = ddrini_pkg::CMD_LM;
          ba = ddrini_pkg::BA_EMR;
          addr = emr_base;
          addr[ddrini_pkg::DRIVE_CAL_BIT_LOW] = 1'b1;
          addr[ddrini_pkg::DRIVE_CAL_BIT_MID] = 1'b1;
          addr[ddrini_pkg::DRIVE_CAL_BIT_HIGH] = 1'b1;
          t_load = 1'b1;
          t_value = TW'(MRD_CYC);
          state_d = ST_EMR_OCD_EXIT;
        end
      end
      ST_EMR_OCD_EXIT:
      begin
        if (t_done)
        begin
          cmd = ddrini_pkg::CMD_LM;
          ba = ddrini_pkg::BA_EMR;
          addr = emr_base;
          t_load = 1'b1;
          t_value = TW'(MRD_CYC);
          state_d = ST_DLL_WAIT;
        end
      end
      ST_DLL_WAIT:
      begin
        if (t_done && dll_done)
        begin
          state_d = ST_DONE;
        end
      end
      ST_DONE:
      begin
        // NOP is held until the user's own scheduler takes over.
        state_d = ST_DONE;
      end
    endcase
  end

  // CKE only ever rises; it falls again only on reset.
  always_ff @(posedge CLOCK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      state_q <= ST_IDLE;
      ref_cnt_q <= 4'h0;
      mr_q <= 13'h0000;
      emr_q <= 13'h0000;
      htsr_q <= 1'b0;
      cke_q <= 1'b0;
    end
    else if (CE_I)
    begin
      state_q <= state_d;
      ref_cnt_q <= ref_cnt_d;
      mr_q <= mr_d;
      emr_q <= emr_d;
      htsr_q <= htsr_d;
      cke_q <= cke_d;
    end
  end

  ddrini_timer #(
    .W(TW)
  ) u_seq_timer (
    .clk_i(CLOCK_I),
    .rst_n_i(RST_N_I),
    .ce_i(CE_I),
    .load_i(t_load),
    .value_i(t_value),
    .done_o(t_done)
  );

  ddrini_timer #(
    .W(TW)
  ) u_dll_timer (
    .clk_i(CLOCK_I),
    .rst_n_i(RST_N_I),
    .ce_i(CE_I),
    .load_i(dll_load),
    .value_i(TW'(ddrini_pkg::DLL_LOCK_CYC)),
    .done_o(dll_done)
  );

  // Bank code steers which of the eight banks or mode registers is hit.
  ddrini_cmd_drv u_cmd_drv (
    .clk_i(CLOCK_I),
    .rst_n_i(RST_N_I),
    .ce_i(CE_I),
    .cmd_i(cmd),
    .ba_i(ba),
    .addr_i(addr),
    .cke_i(cke_q),
    .cs_n_o(DDR_CS_N_O),
    .ras_n_o(DDR_RAS_N_O),
    .cas_n_o(DDR_CAS_N_O),
    .we_n_o(DDR_WE_N_O),
    .ba_o(DDR_BA_O),
    .addr_o(DDR_ADDR_O),
    .cke_o(DDR_CKE_O),
    .odt_o(DDR_ODT_O)
  );

  assign BUSY_O = (state_q != ST_IDLE) && (state_q != ST_DONE);
  assign INIT_DONE_O = (state_q == ST_DONE);

endmodule : ddrini_ctrl

// file: verilog/ddrini_pkg.sv
package ddrini_pkg;

  // Clock of the controller.
  localparam int CLK_PERIOD_NS = 20;

  // Power-up settle time with only NOP or DESELECT on the bus.
  localparam int STABLE_US = 200;
  localparam int STABLE_CYC =
    (STABLE_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Delay from CKE high to the first precharge-all.
  localparam int CKE_WAIT_NS = 400;
  localparam int CKE_WAIT_CYC =
    (CKE_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // DLL lock time after the DLL reset load, in memory clocks.
  localparam int DLL_LOCK_CYC = 200;

  // Defaults for spacing figures that the sequence needs but does not fix.
  localparam int TMRD_CYC_DEF = 2;
  localparam int TRP_NS_DEF = 15;
  localparam int TRFC_NS_DEF = 128;
  localparam int NUM_REFRESH_DEF = 2;

  // Widths.
  localparam int TIMER_W = 16;
  localparam int ADDR_W = 16;
  localparam int BA_W = 3;
  localparam int OPT_W = 13;

  // Bank address codes selecting the mode registers.
  localparam logic [2:0] BA_MR = 3'h0;
  localparam logic [2:0] BA_EMR = 3'h1;
  localparam logic [2:0] BA_EMR2 = 3'h2;
  localparam logic [2:0] BA_EMR3 = 3'h3;

  // Field positions on the address bus.
  localparam int PRECHARGE_ALL_BIT = 10;
  localparam int DLL_DISABLE_BIT = 0;
  localparam int TEST_MODE_BIT = 7;
  localparam int DLL_RESET_BIT = 8;
  localparam int DRIVE_CAL_BIT_LOW = 7;
  localparam int DRIVE_CAL_BIT_MID = 8;
  localparam int DRIVE_CAL_BIT_HIGH = 9;
  localparam int DIFF_STROBE_DISABLE_BIT = 10;
  localparam int HIGH_TEMP_SR_BIT = 7;

  // Pin codes {cs_n, ras_n, cas_n, we_n}.
  localparam logic [3:0] PINS_NOP = 4'h7;
  localparam logic [3:0] PINS_PRE = 4'h2;
  localparam logic [3:0] PINS_LM = 4'h0;
  localparam logic [3:0] PINS_REF = 4'h1;
  localparam logic [3:0] PINS_DESEL = 4'hf;

  typedef enum logic [2:0] {
    CMD_NOP,
    CMD_PRE,
    CMD_LM,
    CMD_REF,
    CMD_DESEL
  } ddrini_cmd_t;

endpackage : ddrini_pkg

// file: verilog/ddrini_timer.sv
`timescale 1ns/1ps
module ddrini_timer #(
  parameter int W = 16
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  // Control
  input wire logic load_i,
  input wire logic [W-1:0] value_i,
  // Status
  output logic done_o
);

  logic [W-1:0] cnt_q;
  logic [W-1:0] cnt_d;

  always_comb
  begin
    cnt_d = cnt_q;
    if (load_i)
    begin
      cnt_d = value_i;
    end
    else if (cnt_q != '0)
    begin
      cnt_d = cnt_q - 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      cnt_q <= '0;
    end
    else if (ce_i)
    begin
      cnt_q <= cnt_d;
    end
  end

  assign done_o = (cnt_q == '0);

endmodule : ddrini_timer
